// ---- include/dlintr_pkg.sv ----
// Package of constants and types shared by the dual LIN mode-control block
package dlintr_pkg;

	// ----------------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int T_MODE_NS     = 10000;   // Enable-high to mode change
	localparam int T_LEAVE_NS    = 10000;   // Enable-low to sleep
	localparam int T_TO_REC_NS   = 10000;   // Both transmit inputs high to release
	localparam int MODE_CYC      = (T_MODE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LEAVE_CYC     = (T_LEAVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TO_REC_CYC    = (T_TO_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TMR_W         = 16;

	// ----------------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------------
	localparam int         ADDR_W     = 4;
	localparam int         DATA_W     = 8;
	localparam logic [3:0] ADDR_STAT  = 4'h0;
	localparam logic [3:0] ADDR_MASK  = 4'h1;
	localparam logic [3:0] ADDR_MODE  = 4'h2;
	localparam logic [7:0] MASK_RST   = 8'h00;
	localparam logic [7:0] STAT_RST   = 8'h00;

	// Status and mask bit positions
	localparam int ST_LOCAL_BIT  = 0;
	localparam int ST_LIN_LINE_ONE_BIT   = 1;
	localparam int ST_LIN_LINE_TWO_BIT   = 2;
	localparam int ST_NORMAL_BIT = 3;
	localparam int ST_SLEEP_BIT  = 4;
	localparam int NUM_EVT       = 5;

	// Synchroniser lanes and their idle levels
	localparam int         SYNC_W   = 7;
	localparam int         S_EN     = 0;
	localparam int         S_TX1    = 1;
	localparam int         S_TX2    = 2;
	localparam int         S_WAKE   = 3;
	localparam int         S_WDIS   = 4;
	localparam int         S_LINE1  = 5;
	localparam int         S_LINE2  = 6;
	localparam logic [6:0] SYNC_RST = 7'h68;

	// ----------------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_STANDBY   = 3'h0,
		ST_MODE_WAIT = 3'h1,
		ST_NORMAL    = 3'h3,
		ST_LEAVE     = 3'h2,
		ST_SLEEP     = 3'h6
	} dlintr_state_t;

	typedef enum logic [1:0] {
		WK_NONE  = 2'h0,
		WK_LOCAL = 2'h1,
		WK_LIN_LINE_ONE  = 2'h2,
		WK_LIN_LINE_TWO  = 2'h3
	} dlintr_wake_t;

endpackage : dlintr_pkg

// ---- verilog/dlintr_sync.sv ----
// Two-stage synchroniser with edge pulses taken from the settled stage
`timescale 1ns/10ps
module dlintr_sync
	import dlintr_pkg::*;
#(
	parameter int         W       = SYNC_W,
	parameter logic [6:0] RST_VAL = SYNC_RST
) (
	input  wire logic         ref_clk_i,
	input  wire logic         sys_rst_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o,
	output logic      [W-1:0] rise_o,
	output logic      [W-1:0] fall_o
);

	logic [W-1:0] meta;
	logic [W-1:0] prev;

	// First stage feeds only the second stage
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			meta   <= RST_VAL[W-1:0];
			sync_o <= RST_VAL[W-1:0];
			prev   <= RST_VAL[W-1:0];
		end else begin
			meta   <= async_i;
			sync_o <= meta;
			prev   <= sync_o;
		end
	end

	assign rise_o = sync_o & ~prev;
	assign fall_o = ~sync_o & prev;

endmodule : dlintr_sync

// ---- verilog/dlintr_timer.sv ----
// Run-while-high counter that flags when a cycle count has been reached
`timescale 1ns/10ps
module dlintr_timer
	import dlintr_pkg::*;
#(
	parameter int COUNT = MODE_CYC
) (
	input  wire logic ref_clk_i,
	input  wire logic sys_rst_i,
	input  wire logic run_i,
	output logic      done_o
);

	localparam logic [TMR_W-1:0] LAST = TMR_W'(COUNT - 1);

	logic [TMR_W-1:0] cnt;

	// Any drop of run restarts the measurement from zero
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt    <= '0;
			done_o <= 1'b0;
		end else if (!run_i) begin
			cnt    <= '0;
			done_o <= 1'b0;
		end else if (cnt == LAST) begin
			done_o <= 1'b1;
		end else begin
			cnt <= cnt + TMR_W'(1);
		end
	end

endmodule : dlintr_timer

// ---- verilog/dlintr_ctrl.sv ----
// Mode, wake and line control for a dual LIN physical-layer transceiver
//
// Overview of operation
// - Enable high moves the device to normal mode; enable idles low.
// - Local wake is active low and caught on its falling edge.
// - Transmit low in normal mode drives the channel's line dominant.
// - Transmit high releases the line recessive; receive then reads high unless another node holds the line dominant.
// - Receive output is low whenever its line is dominant in normal mode.
// - Wake-disable high masks channel two bus activity as a wake source.
// - One shared mode and sub-mode, chosen by enable and transmit one.
// - Stand-by, normal and sleep; normal has low slope, normal slope, flash.
// - Sleep floats inhibits and receive outputs and drops termination.
// - Inhibit outputs drive high in normal and stand-by.
// - Stand-by: receive one low after local or any bus wake.
// - Stand-by: receive two low only after channel two bus wake.
// - Stand-by after power-up without wake: receive one high.
// - Stand-by: strong pull-down on transmit one for local wake, else weak.
// - Normal mode: receive follows own line, line follows own transmit.
// - Transmit one level at mode change picks normal or low slope outside flash mode.
// - Wake indications clear on entry to normal mode.
// - Only the first wake event is captured until cleared.
`timescale 1ns/10ps
module dlintr_ctrl
	import dlintr_pkg::*;
#(
	parameter int MODE_CYCLES   = MODE_CYC,
	parameter int LEAVE_CYCLES  = LEAVE_CYC,
	parameter int TO_REC_CYCLES = TO_REC_CYC
) (
	input  wire logic              ref_clk_i,
	input  wire logic              sys_rst_i,
	// Host side
	input  wire logic              enable_i,
	input  wire logic              xmit_in_ch_one_i,
	input  wire logic              xmit_in_ch_two_i,
	input  wire logic              ch_two_wake_disable_i,
	output logic                   recv_out_ch_one_o,
	output logic                   recv_out_ch_one_oe_o,
	output logic                   recv_out_ch_two_o,
	output logic                   recv_out_ch_two_oe_o,
	output logic                   xmit_pd_strong_o,
	output logic                   xmit_pd_weak_o,
	// Wake and inhibit
	input  wire logic              local_wake_in_i,
	output logic                   inhibit_out_one_o,
	output logic                   inhibit_out_one_oe_o,
	output logic                   inhibit_out_two_o,
	output logic                   inhibit_out_two_oe_o,
	// LIN lines, open drain
	input  wire logic              lin_line_one_i,
	output logic                   lin_line_one_o,
	output logic                   lin_line_one_oe_o,
	input  wire logic              lin_line_two_i,
	output logic                   lin_line_two_o,
	output logic                   lin_line_two_oe_o,
	output logic                   term_on_o,
	output logic                   slope_normal_o,
	output logic                   flash_mode_o,
	// Register port
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [DATA_W-1:0] rdata_o,
	output logic                   irq_o
);

	// ----------------------------------------------------------------------
	// Input synchronisation
	// ----------------------------------------------------------------------
	logic [SYNC_W-1:0] pins;
	logic [SYNC_W-1:0] syn;
	logic [SYNC_W-1:0] rise;
	logic [SYNC_W-1:0] fall;

	assign pins = {lin_line_two_i, lin_line_one_i, ch_two_wake_disable_i,
		local_wake_in_i, xmit_in_ch_two_i, xmit_in_ch_one_i, enable_i};

	dlintr_sync #(
		.W       (SYNC_W),
		.RST_VAL (SYNC_RST)
	) u_sync (
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.async_i   (pins),
		.sync_o    (syn),
		.rise_o    (rise),
		.fall_o    (fall)
	);

	logic en;
	logic tx1;
	logic tx2;
	assign en  = syn[S_EN];
	assign tx1 = syn[S_TX1];
	assign tx2 = syn[S_TX2];

	// ----------------------------------------------------------------------
	// Mode timers
	// ----------------------------------------------------------------------
	dlintr_state_t state;
	dlintr_state_t next_state;
	logic          mode_done;
	logic          leave_done;
	logic          rec_done;
	logic          released;

	dlintr_timer #(
		.COUNT (MODE_CYCLES)
	) u_mode_tmr (
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.run_i     (state == ST_MODE_WAIT),
		.done_o    (mode_done)
	);

	dlintr_timer #(
		.COUNT (LEAVE_CYCLES)
	) u_leave_tmr (
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.run_i     (state == ST_LEAVE),
		.done_o    (leave_done)
	);

	// After any mode change the drivers stay recessive until both
	// transmit inputs have been high long enough
	dlintr_timer #(
		.COUNT (TO_REC_CYCLES)
	) u_rec_tmr (
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.run_i     (state == ST_NORMAL && tx1 && tx2 && !released),
		.done_o    (rec_done)
	);

	// ----------------------------------------------------------------------
	// Wake detection
	// ----------------------------------------------------------------------
	logic         wake_window;
	logic         ev_local;
	logic         ev_lin_line_one;
	logic         ev_lin_line_two;
	logic         wake_any;
	dlintr_wake_t wake_src;
	logic         enter_normal;

	assign wake_window = (state == ST_SLEEP) || (state == ST_STANDBY);
	assign ev_local = wake_window && fall[S_WAKE];
	// A bus wake is the dominant-to-recessive release of the line
	assign ev_lin_line_one  = wake_window && rise[S_LINE1];
	assign ev_lin_line_two  = wake_window && rise[S_LINE2] && !syn[S_WDIS];
	assign wake_any = ev_local || ev_lin_line_one || ev_lin_line_two;
	assign enter_normal = (next_state == ST_NORMAL) && (state == ST_MODE_WAIT);

	// ----------------------------------------------------------------------
	// Mode state machine
	// ----------------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			ST_STANDBY: begin
				if (en) begin
					next_state = ST_MODE_WAIT;
				end
			end
			ST_MODE_WAIT: begin
				if (!en) begin
					next_state = ST_STANDBY;
				end else if (mode_done) begin
					next_state = ST_NORMAL;
				end
			end
			ST_NORMAL: begin
				if (!en) begin
					next_state = ST_LEAVE;
				end
			end
			ST_LEAVE: begin
				if (en) begin
					next_state = ST_NORMAL;
				end else if (leave_done) begin
					next_state = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (wake_any) begin
					next_state = ST_STANDBY;
				end else if (en) begin
					next_state = ST_MODE_WAIT;
				end
			end
			default: begin
				next_state = ST_STANDBY;
			end
		endcase
	end

	// Power-up lands in stand-by
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state <= ST_STANDBY;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------------
	// Sub-mode selection, shared by both channels
	// ----------------------------------------------------------------------
	logic fl_fall_seen;
	logic fl_seq_done;
	logic slope_normal;
	logic flash_mode;

	// Flash toggles on a fall then rise of transmit one during a short
	// enable-low gap; a gap longer than the leave time goes to sleep
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			fl_fall_seen <= 1'b0;
			fl_seq_done  <= 1'b0;
		end else if (state != ST_LEAVE) begin
			fl_fall_seen <= 1'b0;
			fl_seq_done  <= 1'b0;
		end else begin
			if (fall[S_TX1]) begin
				fl_fall_seen <= 1'b1;
			end
			if (fl_fall_seen && rise[S_TX1]) begin
				fl_seq_done <= 1'b1;
			end
		end
	end

	// Sub-mode survives sleep so that flash resumes on the next enable
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			slope_normal <= 1'b0;
			flash_mode   <= 1'b0;
		end else if (enter_normal && !flash_mode) begin
			slope_normal <= tx1;
		end else if (state == ST_LEAVE && en && fl_seq_done) begin
			flash_mode <= !flash_mode;
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			released <= 1'b0;
		end else if (state != ST_NORMAL || next_state != ST_NORMAL) begin
			released <= 1'b0;
		end else if (rec_done) begin
			released <= 1'b1;
		end
	end

	// ----------------------------------------------------------------------
	// Wake source capture
	// ----------------------------------------------------------------------
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wake_src <= WK_NONE;
		end else if (enter_normal) begin
			wake_src <= WK_NONE;
		end else if (wake_src == WK_NONE) begin
			if (ev_local) begin
				wake_src <= WK_LOCAL;
			end else if (ev_lin_line_one) begin
				wake_src <= WK_LIN_LINE_ONE;
			end else if (ev_lin_line_two) begin
				wake_src <= WK_LIN_LINE_TWO;
			end
		end
	end

	// ----------------------------------------------------------------------
	// Pin drive, all registered
	// ----------------------------------------------------------------------
	logic comm;
	logic asleep;
	assign comm   = (state == ST_NORMAL) || (state == ST_LEAVE);
	assign asleep = (state == ST_SLEEP);

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			lin_line_one_o    <= 1'b0;
			lin_line_two_o    <= 1'b0;
			lin_line_one_oe_o <= 1'b0;
			lin_line_two_oe_o <= 1'b0;
		end else begin
			lin_line_one_o    <= 1'b0;
			lin_line_two_o    <= 1'b0;
			lin_line_one_oe_o <= (state == ST_NORMAL) && released && !tx1;
			lin_line_two_oe_o <= (state == ST_NORMAL) && released && !tx2;
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			recv_out_ch_one_o    <= 1'b1;
			recv_out_ch_two_o    <= 1'b1;
			recv_out_ch_one_oe_o <= 1'b0;
			recv_out_ch_two_oe_o <= 1'b0;
		end else begin
			recv_out_ch_one_oe_o <= !asleep;
			recv_out_ch_two_oe_o <= !asleep;
			if (comm) begin
				recv_out_ch_one_o <= syn[S_LINE1];
				recv_out_ch_two_o <= syn[S_LINE2];
			end else begin
				recv_out_ch_one_o <= (wake_src == WK_NONE);
				recv_out_ch_two_o <= (wake_src != WK_LIN_LINE_TWO);
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			xmit_pd_strong_o <= 1'b0;
			xmit_pd_weak_o   <= 1'b0;
		end else begin
			xmit_pd_strong_o <= !comm && !asleep && (wake_src == WK_LOCAL);
			xmit_pd_weak_o   <= !comm && !asleep && (wake_src != WK_LOCAL);
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			inhibit_out_one_o    <= 1'b0;
			inhibit_out_two_o    <= 1'b0;
			inhibit_out_one_oe_o <= 1'b0;
			inhibit_out_two_oe_o <= 1'b0;
			term_on_o            <= 1'b0;
			slope_normal_o       <= 1'b0;
			flash_mode_o         <= 1'b0;
		end else begin
			inhibit_out_one_o    <= !asleep;
			inhibit_out_two_o    <= !asleep;
			inhibit_out_one_oe_o <= !asleep;
			inhibit_out_two_oe_o <= !asleep;
			term_on_o            <= !asleep;
			slope_normal_o       <= slope_normal;
			flash_mode_o         <= flash_mode;
		end
	end

	// ----------------------------------------------------------------------
	// Registers and interrupt
	// ----------------------------------------------------------------------
	logic [NUM_EVT-1:0] evt;
	logic [DATA_W-1:0]  status;
	logic [DATA_W-1:0]  mask;
	logic               rd_stat;

	assign evt[ST_LOCAL_BIT]  = ev_local && (wake_src == WK_NONE);
	assign evt[ST_LIN_LINE_ONE_BIT]   = ev_lin_line_one && !ev_local && (wake_src == WK_NONE);
	assign evt[ST_LIN_LINE_TWO_BIT]   = ev_lin_line_two && !ev_local && !ev_lin_line_one && (wake_src == WK_NONE);
	assign evt[ST_NORMAL_BIT] = enter_normal;
	assign evt[ST_SLEEP_BIT]  = (next_state == ST_SLEEP) && (state == ST_LEAVE);
	assign rd_stat = rd_i && (addr_i == ADDR_STAT);

	// A read clears the sticky bits, but an event in the same cycle stays
	genvar g;
	generate
		for (g = 0; g < DATA_W; g++) begin : g_stat
			if (g < NUM_EVT) begin : g_live
				always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
					if (sys_rst_i) begin
						status[g] <= STAT_RST[g];
					end else if (evt[g]) begin
						status[g] <= 1'b1;
					end else if (rd_stat) begin
						status[g] <= 1'b0;
					end
				end
			end else begin : g_zero
				assign status[g] = 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			mask <= MASK_RST;
		end else if (wr_i && addr_i == ADDR_MASK) begin
			mask <= wdata_i;
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rdata_o <= '0;
		end else if (rd_i) begin
			case (addr_i)
				ADDR_STAT: rdata_o <= status;
				ADDR_MASK: rdata_o <= mask;
				ADDR_MODE: rdata_o <= {released, flash_mode, slope_normal, wake_src, state};
				default:   rdata_o <= '0;
			endcase
		end else begin
			rdata_o <= '0;
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(status & mask);
		end
	end

endmodule : dlintr_ctrl

// ---- dv/dlintr_host_model.sv ----
// Host controller pins and LIN line model facing the mode-control block
`timescale 1ns/10ps
module dlintr_host_model (
	input  wire logic       en_drive_i,
	input  wire logic       en_val_i,
	input  wire logic       wk_low_i,
	input  wire logic [1:0] remote_dom_i,
	input  wire logic [1:0] line_oe_i,
	output logic            enable_o,
	output logic            local_wake_o,
	output logic [1:0]      lin_line_o
);
	// Undriven enable settles low through its pull-down
	assign enable_o     = en_drive_i & en_val_i;
	// Wake pin idles high, so only a deliberate pull gives a falling edge
	assign local_wake_o = ~wk_low_i;
	// Wired-AND line: any driver forces dominant, else the pull-up wins
	assign lin_line_o   = ~(line_oe_i | remote_dom_i);
endmodule : dlintr_host_model

// ---- dv/dlintr_ctrl_asserts.sv ----
// Port-level checks for the dual LIN mode-control block
`timescale 1ns/10ps
module dlintr_ctrl_asserts
	import dlintr_pkg::*;
(
	input wire logic              ref_clk_i,
	input wire logic              sys_rst_i,
	input wire logic              xmit_in_ch_one_i,
	input wire logic              lin_line_one_i,
	input wire logic              rd_i,
	input wire logic              recv_out_ch_one_o,
	input wire logic              recv_out_ch_one_oe_o,
	input wire logic              recv_out_ch_two_o,
	input wire logic              recv_out_ch_two_oe_o,
	input wire logic              xmit_pd_strong_o,
	input wire logic              xmit_pd_weak_o,
	input wire logic              inhibit_out_one_o,
	input wire logic              inhibit_out_one_oe_o,
	input wire logic              inhibit_out_two_o,
	input wire logic              inhibit_out_two_oe_o,
	input wire logic              lin_line_one_oe_o,
	input wire logic              term_on_o,
	input wire logic [DATA_W-1:0] rdata_o
);
	// ----------------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------------
	// Low at the first edge after reset, while outputs still show reset values
	logic ran;
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			ran <= 1'b0;
		else
			ran <= 1'b1;
	end
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	// ----------------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------------
	a_sleep_floats: assert property (ran && !inhibit_out_one_oe_o |-> !term_on_o &&
		!recv_out_ch_one_oe_o && !recv_out_ch_two_oe_o && !lin_line_one_oe_o)
		else $error("outputs not floating in sleep");
	a_inhibit_high: assert property (inhibit_out_one_oe_o |-> inhibit_out_one_o &&
		term_on_o && recv_out_ch_one_oe_o) else $error("inhibit not high while awake");
	a_channels_same: assert property (inhibit_out_two_oe_o == inhibit_out_one_oe_o &&
		inhibit_out_two_o == inhibit_out_one_o) else $error("channels differ in mode");
	a_drive_needs_tx: assert property (lin_line_one_oe_o |-> !$past(xmit_in_ch_one_i, 3))
		else $error("line driven without low transmit");
	a_recv_follows: assert property ((recv_out_ch_one_oe_o && !xmit_pd_weak_o &&
		!xmit_pd_strong_o)[*4] |-> recv_out_ch_one_o == $past(lin_line_one_i, 3))
		else $error("receive does not follow line");
	a_local_marks: assert property (xmit_pd_strong_o |-> !recv_out_ch_one_o &&
		recv_out_ch_two_o && !xmit_pd_weak_o) else $error("local wake marks wrong");
	a_bus_two_marks: assert property (recv_out_ch_two_oe_o && !recv_out_ch_two_o &&
		xmit_pd_weak_o |-> !recv_out_ch_one_o) else $error("bus two wake marks wrong");
	a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data outside read cycle");
	c_local: cover property (xmit_pd_strong_o);
	c_bus_two: cover property (xmit_pd_weak_o && !recv_out_ch_two_o);
	c_drive: cover property (lin_line_one_oe_o);
	c_sleep: cover property (ran && !inhibit_out_one_oe_o);
endmodule : dlintr_ctrl_asserts

bind dlintr_ctrl dlintr_ctrl_asserts u_asserts (
	.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .xmit_in_ch_one_i(xmit_in_ch_one_i),
	.lin_line_one_i(lin_line_one_i), .rd_i(rd_i), .recv_out_ch_one_o(recv_out_ch_one_o),
	.recv_out_ch_one_oe_o(recv_out_ch_one_oe_o), .recv_out_ch_two_o(recv_out_ch_two_o),
	.recv_out_ch_two_oe_o(recv_out_ch_two_oe_o), .xmit_pd_strong_o(xmit_pd_strong_o),
	.xmit_pd_weak_o(xmit_pd_weak_o), .inhibit_out_one_o(inhibit_out_one_o),
	.inhibit_out_one_oe_o(inhibit_out_one_oe_o), .inhibit_out_two_o(inhibit_out_two_o),
	.inhibit_out_two_oe_o(inhibit_out_two_oe_o), .lin_line_one_oe_o(lin_line_one_oe_o),
	.term_on_o(term_on_o), .rdata_o(rdata_o)
);

// ---- dv/dlintr_ctrl_bench.sv ----
// Self-checking bench for the dual LIN mode-control block
`timescale 1ns/10ps
module dlintr_ctrl_bench
	import dlintr_pkg::*;
;
	logic       clk, rst, en_drive, en_val, wk_low, tx1, tx2, wdis, wr, rd;
	logic       enable, wake, r1, r1oe, r2, r2oe, pds, pdw, inhibit_out_one, inh1oe;
	logic       irq, flash, slope, term;
	logic [1:0] remote, line_oe, line;
	logic [3:0] addr;
	logic [7:0] wdata, rdata;
	logic [7:0] wake_exp [3] = '{8'hed, 8'heb, 8'he3};
	integer     failures, total_checks, seed, i, k;
	wire  [7:0] pins  = {term, inh1oe, r1oe, r1, r2, pds, pdw, inhibit_out_one};
	wire  [7:0] modes = {5'h00, irq, flash, slope};

	dlintr_ctrl #(.MODE_CYCLES(4), .LEAVE_CYCLES(12), .TO_REC_CYCLES(4)) dut (
		.ref_clk_i(clk), .sys_rst_i(rst), .enable_i(enable), .xmit_in_ch_one_i(tx1),
		.xmit_in_ch_two_i(tx2), .ch_two_wake_disable_i(wdis), .recv_out_ch_one_o(r1),
		.recv_out_ch_one_oe_o(r1oe), .recv_out_ch_two_o(r2), .recv_out_ch_two_oe_o(r2oe),
		.xmit_pd_strong_o(pds), .xmit_pd_weak_o(pdw), .local_wake_in_i(wake),
		.inhibit_out_one_o(inhibit_out_one), .inhibit_out_one_oe_o(inh1oe), .inhibit_out_two_o(),
		.inhibit_out_two_oe_o(), .lin_line_one_i(line[0]), .lin_line_one_o(),
		.lin_line_one_oe_o(line_oe[0]), .lin_line_two_i(line[1]), .lin_line_two_o(),
		.lin_line_two_oe_o(line_oe[1]), .term_on_o(term), .slope_normal_o(slope),
		.flash_mode_o(flash), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata), .irq_o(irq));
	dlintr_host_model host (.en_drive_i(en_drive), .en_val_i(en_val), .wk_low_i(wk_low),
		.remote_dom_i(remote), .line_oe_i(line_oe), .enable_o(enable),
		.local_wake_o(wake), .lin_line_o(line));

	// ----------------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks = total_checks + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Samples at the falling edge so settled outputs are compared
	task automatic look(input logic sel, input logic [7:0] mask, input logic [7:0] exp);
		@(negedge clk);
		chk((sel ? modes : pins) & mask, exp);
		@(posedge clk);
	endtask : look

	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask : reg_wr

	task automatic reg_rd(input logic [3:0] a, input logic [7:0] mask, input logic [7:0] exp);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata & mask, exp);
		@(posedge clk);
	endtask : reg_rd

	// 0: normal reached, 1: asleep, 2: wake marks shown
	task automatic wait_for(input int what);
		for (k = 0; k < 100; k++) begin
			@(negedge clk);
			if ((what == 0 && pds === 1'b0 && pdw === 1'b0 && inh1oe === 1'b1) ||
			    (what == 1 && inh1oe === 1'b0) || (what == 2 && (pds | pdw) === 1'b1)) begin
				@(posedge clk);
				return;
			end
		end
		failures = failures + 1;
		$display("ERROR %0t: wait ran out", $time);
		tally_and_finish();
	endtask : wait_for

	// 0: local wake pull, 1/2: dominant pulse on line one/two
	task automatic evt(input int c);
		if (c == 0)
			wk_low <= 1'b1;
		else
			remote[c-1] <= 1'b1;
		repeat (3) @(posedge clk);
		wk_low <= 1'b0;
		remote <= 2'b00;
		repeat (8) @(posedge clk);
	endtask : evt

	// Short enable-low window with a fall and rise of transmit one
	task automatic do_flash();
		en_val <= 1'b0;
		repeat (2) @(posedge clk);
		tx1 <= 1'b0;
		repeat (2) @(posedge clk);
		tx1 <= 1'b1;
		repeat (2) @(posedge clk);
		en_val <= 1'b1;
		repeat (20) @(posedge clk);
	endtask : do_flash

	// ----------------------------------------------------------------------
	// Stimulus
	// ----------------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		{rst, tx1, tx2} = 3'h7;
		{en_drive, en_val, wk_low, wdis, wr, rd} = 6'h00;
		{addr, wdata, remote} = 14'h0000;
		{failures, total_checks, seed} = {32'd0, 32'd0, 32'd16};
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		look(1'b0, 8'hff, 8'hfb);
		reg_rd(4'h5, 8'hff, 8'h00);
		reg_wr(ADDR_MASK, 8'h1f);
		reg_rd(ADDR_MASK, 8'hff, 8'h1f);
		reg_wr(ADDR_MODE, 8'hff);
		reg_rd(ADDR_MODE, 8'h1f, 8'h00);
		en_drive <= 1'b1;
		en_val   <= 1'b1;
		wait_for(0);
		look(1'b0, 8'hff, 8'hf9);
		look(1'b1, 8'h07, 8'h05);
		reg_rd(ADDR_MODE, 8'h07, 8'h03);
		reg_rd(ADDR_STAT, 8'hff, 8'h08);
		look(1'b1, 8'h04, 8'h00);
		repeat (8) @(posedge clk);
		for (i = 0; i < 24; i++) begin
			{tx1, tx2, remote} <= 4'($random(seed));
			repeat (7) @(posedge clk);
			@(negedge clk);
			chk({4'h0, line_oe, r1, r2}, {4'h0, ~tx2, ~tx1, tx1 & ~remote[0], tx2 & ~remote[1]});
			@(posedge clk);
		end
		{tx1, tx2, remote} <= 4'hc;
		repeat (8) @(posedge clk);
		do_flash();
		look(1'b1, 8'h03, 8'h03);
		do_flash();
		look(1'b1, 8'h03, 8'h01);
		en_val <= 1'b0;
		wait_for(1);
		look(1'b0, 8'he1, 8'h00);
		reg_rd(ADDR_STAT, 8'h10, 8'h10);
		wdis <= 1'b1;
		evt(2);
		look(1'b0, 8'he1, 8'h00);
		wdis <= 1'b0;
		for (i = 0; i < 3; i++) begin
			evt(i);
			wait_for(2);
			look(1'b0, 8'hff, wake_exp[i]);
			evt(i == 0 ? 1 : 0);
			look(1'b0, 8'hff, wake_exp[i]);
			reg_wr(ADDR_MASK, 8'h00);
			look(1'b1, 8'h04, 8'h00);
			reg_wr(ADDR_MASK, 8'h1f);
			look(1'b1, 8'h04, 8'h04);
			reg_rd(ADDR_STAT, 8'h01 << i, 8'h01 << i);
			tx1    <= 1'b0;
			en_val <= 1'b1;
			wait_for(0);
			look(1'b0, 8'h1e, 8'h18);
			look(1'b1, 8'h03, 8'h00);
			tx1    <= 1'b1;
			en_val <= 1'b0;
			wait_for(1);
			reg_rd(ADDR_STAT, 8'h18, 8'h18);
		end
		tally_and_finish();
	end
endmodule : dlintr_ctrl_bench
